// File: src/jtag_packet_pkg.sv
package jtag_packet_pkg;

	// ----------------------------------------------------------------
	// Scan geometry and instruction codes
	// ----------------------------------------------------------------
	localparam int unsigned IR_WIDTH     = 8;
	localparam int unsigned CTRL_WIDTH   = 12;
	localparam int unsigned PACKET_WIDTH = 72;
	localparam logic [7:0]  INSTR_CONTROL = 8'h1A;    // Loads the 12-bit control register
	localparam logic [7:0]  INSTR_PACKET  = 8'h19;    // Loads the 72-bit register packet
	localparam logic [7:0]  INSTR_BYPASS  = 8'hFF;
	localparam logic [7:0]  IR_CAPTURE    = 8'h01;    // Fixed low 01 pattern on instruction capture

	// ----------------------------------------------------------------
	// Register indices within the packet map
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_SUPPLY_FLAGS_A  = 8'h00;
	localparam logic [7:0] REG_SUPPLY_FLAGS_B  = 8'h01;
	localparam logic [7:0] REG_SUPPLY_FLAGS_C  = 8'h02;
	localparam logic [7:0] REG_DRIVEN_HIGH     = 8'h03;
	localparam logic [7:0] REG_DRIVEN_LOW      = 8'h04;
	localparam logic [7:0] REG_LOGIC_LEVELS    = 8'h06;
	localparam logic [7:0] REG_RESULT_LOW      = 8'h07;
	localparam logic [7:0] REG_RESULT_HIGH     = 8'h08;
	localparam logic [7:0] REG_INPUT_SELECT    = 8'h09;
	localparam logic [7:0] REG_DRIVE_HIGH      = 8'h0E;
	localparam logic [7:0] REG_DRIVE_LOW       = 8'h0F;
	localparam logic [7:0] REG_INPUT_OVERRIDE  = 8'h11;

	// ----------------------------------------------------------------
	// Byte positions inside the packet (low bit of each byte)
	// ----------------------------------------------------------------
	localparam int unsigned BYTE_FLAGS_A   = 64;
	localparam int unsigned BYTE_FLAGS_B   = 56;
	localparam int unsigned BYTE_FLAGS_C   = 48;
	localparam int unsigned BYTE_RES_LOW   = 40;
	localparam int unsigned BYTE_RES_HIGH  = 32;
	localparam int unsigned BYTE_SELECT    = 24;
	localparam int unsigned BYTE_INPUTS    = 16;
	localparam int unsigned BYTE_DRIVE_HI  = 8;
	localparam int unsigned BYTE_DRIVE_LO  = 0;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_LOW_LSB    = 0;     // Low output byte mode, two bits
	localparam int unsigned CTRL_HIGH_LSB   = 2;     // High output byte mode, two bits
	localparam int unsigned CTRL_INPUT_LSB  = 4;     // Input byte mode, two bits
	localparam int unsigned CTRL_SELECT_WR  = 6;     // Enables selector writes
	localparam logic [1:0]  MODE_SETTINGS   = 2'h0;  // Read stored settings
	localparam logic [1:0]  MODE_LIVE       = 2'h1;  // Read live levels
	localparam logic [1:0]  MODE_WRITE      = 2'h2;  // Update takes the byte

	// ----------------------------------------------------------------
	// Reset values of the writable state
	// ----------------------------------------------------------------
	localparam logic [11:0] CTRL_RESET       = 12'h000;
	localparam logic [7:0]  DRIVE_HIGH_RESET = 8'h04;
	localparam logic [5:0]  DRIVE_LOW_RESET  = 6'h00;
	localparam logic [3:0]  SELECT_RESET     = 4'h0;
	localparam logic        ATTEN_RESET      = 1'b0;
	localparam logic [2:0]  OVERRIDE_RESET   = 3'h0;

	// ----------------------------------------------------------------
	// Test access port states, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [15:0] {
		TAP_RESET      = 16'h0001,
		TAP_IDLE       = 16'h0002,
		TAP_SEL_DR     = 16'h0004,
		TAP_CAPTURE_DR = 16'h0008,
		TAP_SHIFT_DR   = 16'h0010,
		TAP_EXIT1_DR   = 16'h0020,
		TAP_PAUSE_DR   = 16'h0040,
		TAP_EXIT2_DR   = 16'h0080,
		TAP_UPDATE_DR  = 16'h0100,
		TAP_SEL_IR     = 16'h0200,
		TAP_CAPTURE_IR = 16'h0400,
		TAP_SHIFT_IR   = 16'h0800,
		TAP_EXIT1_IR   = 16'h1000,
		TAP_PAUSE_IR   = 16'h2000,
		TAP_EXIT2_IR   = 16'h4000,
		TAP_UPDATE_IR  = 16'h8000
	} tap_state_type;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic trst_n;
	} scan_pins_type;

	typedef struct packed {
		logic [19:0] supply_flags;   // Comparator pairs, [19] is first input A
		logic [13:0] driven_levels;  // [13] is first output
		logic [2:0]  logic_levels;   // [2] is second input
		logic [11:0] result;         // Conversion result, [0] is D0
	} live_status_type;

	typedef struct packed {
		logic [7:0] drive_high;
		logic [5:0] drive_low;       // [5] is drive_setting_nine
		logic [2:0] override;        // [2] is second input
		logic [3:0] select;          // [0] is select bit zero
		logic       atten;
	} settings_type;

endpackage : jtag_packet_pkg

// File: src/scan_pin_sync.sv
`timescale 1ns/1ps

module scan_pin_sync (
	input  wire logic                          core_clk,
	input  wire logic                          rst_n,
	input  wire jtag_packet_pkg::scan_pins_type pins,
	output jtag_packet_pkg::scan_pins_type      pins_sync,
	output logic                               tck_rise,
	output logic                               tck_fall
);

	typedef struct packed {
		jtag_packet_pkg::scan_pins_type meta;
		jtag_packet_pkg::scan_pins_type sync;
		logic                           tck_last;
	} sync_state_type;

	sync_state_type state;
	sync_state_type next_state;

	// ----------------------------------------------------------------
	// Two-stage capture; edges only look at the second stage
	// ----------------------------------------------------------------
	always_comb begin
		next_state          = state;
		next_state.meta     = pins;
		next_state.sync     = state.meta;
		next_state.tck_last = state.sync.tck;
	end

	// Reset parks the test reset asserted so the port starts in its reset state
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Edge pulses last one core cycle
	assign pins_sync = state.sync;
	assign tck_rise  = state.sync.tck & ~state.tck_last;
	assign tck_fall  = ~state.sync.tck & state.tck_last;

endmodule : scan_pin_sync

// File: src/jtag_status_output_register_packet.sv
`timescale 1ns/1ps

// Summary of operation
// [RULE_01] Low byte mode 00 returns settings nine-fourteen
// [RULE_02] Low byte mode 01 returns driven levels
// [RULE_03] Non-functional packet bits always read one
// [RULE_04] Reset: drive high 04, low zero, selector zero
// [RULE_05] Reset clears the three override input bits
// [RULE_06] Status bytes follow live inputs, not constants
// [RULE_07] Status bytes read-only; selector, drives, override writable
// [RULE_08] Host loads control instruction, shifts 040
// [RULE_09] Host loads packet instruction, shifts 72 bits
// [RULE_10] Selector write picks input and starts conversion
// [RULE_11] Host waits about 100us before reading
// [RULE_12] Next 72-bit scan returns packet with result
// [RULE_13] Selector updates only while control bit six set
// [RULE_14] Capture and update on TAP states, LSB first

module jtag_status_output_register_packet (
	input  wire logic                             core_clk,
	input  wire logic                             rst_n,
	input  wire logic                             tck,
	input  wire logic                             tms,
	input  wire logic                             tdi,
	input  wire logic                             trst_n,
	output logic                                  tdo,
	output logic                                  tdo_oe,
	input  wire jtag_packet_pkg::live_status_type live,
	output jtag_packet_pkg::settings_type         settings,
	output logic                                  conversion_start
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		jtag_packet_pkg::tap_state_type tap;
		logic [7:0]                     ir_shift;
		logic [7:0]                     ir;
		logic [11:0]                    ctrl;
		logic [71:0]                    dr_shift;
		jtag_packet_pkg::settings_type  set;
		logic                           start;
		logic                           tdo;
		logic                           tdo_oe;
	} packet_state_type;

	packet_state_type state;
	packet_state_type next_state;

	jtag_packet_pkg::scan_pins_type pins_raw;
	jtag_packet_pkg::scan_pins_type pins;
	logic                           tck_rise;
	logic                           tck_fall;
	logic [71:0]                    packet_image;

	// ----------------------------------------------------------------
	// Field positions of the partial bytes
	// ----------------------------------------------------------------
	// These partial fields sit high in their byte so the unused low bits read one; the input byte's bit 7 reads one too
	localparam int unsigned FLAGS_C_LSB  = jtag_packet_pkg::BYTE_FLAGS_C + 4;
	localparam int unsigned SELECT_LSB   = jtag_packet_pkg::BYTE_SELECT + 4;
	localparam int unsigned ATTEN_BIT    = jtag_packet_pkg::BYTE_SELECT + 3;
	localparam int unsigned INPUTS_LSB   = jtag_packet_pkg::BYTE_INPUTS + 4;
	localparam int unsigned DRIVE_LO_LSB = jtag_packet_pkg::BYTE_DRIVE_LO + 2;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Packet bytes list the first index at the high bit
	function automatic logic [3:0] rev4(input logic [3:0] v);
		rev4 = {v[0], v[1], v[2], v[3]};
	endfunction : rev4

	function automatic logic [7:0] rev8(input logic [7:0] v);
		rev8 = {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
	endfunction : rev8

	function automatic jtag_packet_pkg::tap_state_type tap_next(
		input jtag_packet_pkg::tap_state_type s,
		input logic                           m
	);
		case (s)
			jtag_packet_pkg::TAP_RESET:      tap_next = m ? jtag_packet_pkg::TAP_RESET
			                                             : jtag_packet_pkg::TAP_IDLE;
			jtag_packet_pkg::TAP_IDLE:       tap_next = m ? jtag_packet_pkg::TAP_SEL_DR
			                                             : jtag_packet_pkg::TAP_IDLE;
			jtag_packet_pkg::TAP_SEL_DR:     tap_next = m ? jtag_packet_pkg::TAP_SEL_IR
			                                             : jtag_packet_pkg::TAP_CAPTURE_DR;
			jtag_packet_pkg::TAP_CAPTURE_DR: tap_next = m ? jtag_packet_pkg::TAP_EXIT1_DR
			                                             : jtag_packet_pkg::TAP_SHIFT_DR;
			jtag_packet_pkg::TAP_SHIFT_DR:   tap_next = m ? jtag_packet_pkg::TAP_EXIT1_DR
			                                             : jtag_packet_pkg::TAP_SHIFT_DR;
			jtag_packet_pkg::TAP_EXIT1_DR:   tap_next = m ? jtag_packet_pkg::TAP_UPDATE_DR
			                                             : jtag_packet_pkg::TAP_PAUSE_DR;
			jtag_packet_pkg::TAP_PAUSE_DR:   tap_next = m ? jtag_packet_pkg::TAP_EXIT2_DR
			                                             : jtag_packet_pkg::TAP_PAUSE_DR;
			jtag_packet_pkg::TAP_EXIT2_DR:   tap_next = m ? jtag_packet_pkg::TAP_UPDATE_DR
			                                             : jtag_packet_pkg::TAP_SHIFT_DR;
			jtag_packet_pkg::TAP_UPDATE_DR:  tap_next = m ? jtag_packet_pkg::TAP_SEL_DR
			                                             : jtag_packet_pkg::TAP_IDLE;
			jtag_packet_pkg::TAP_SEL_IR:     tap_next = m ? jtag_packet_pkg::TAP_RESET
			                                             : jtag_packet_pkg::TAP_CAPTURE_IR;
			jtag_packet_pkg::TAP_CAPTURE_IR: tap_next = m ? jtag_packet_pkg::TAP_EXIT1_IR
			                                             : jtag_packet_pkg::TAP_SHIFT_IR;
			jtag_packet_pkg::TAP_SHIFT_IR:   tap_next = m ? jtag_packet_pkg::TAP_EXIT1_IR
			                                             : jtag_packet_pkg::TAP_SHIFT_IR;
			jtag_packet_pkg::TAP_EXIT1_IR:   tap_next = m ? jtag_packet_pkg::TAP_UPDATE_IR
			                                             : jtag_packet_pkg::TAP_PAUSE_IR;
			jtag_packet_pkg::TAP_PAUSE_IR:   tap_next = m ? jtag_packet_pkg::TAP_EXIT2_IR
			                                             : jtag_packet_pkg::TAP_PAUSE_IR;
			jtag_packet_pkg::TAP_EXIT2_IR:   tap_next = m ? jtag_packet_pkg::TAP_UPDATE_IR
			                                             : jtag_packet_pkg::TAP_SHIFT_IR;
			jtag_packet_pkg::TAP_UPDATE_IR:  tap_next = m ? jtag_packet_pkg::TAP_SEL_DR
			                                             : jtag_packet_pkg::TAP_IDLE;
			default:                         tap_next = jtag_packet_pkg::TAP_RESET;
		endcase
	endfunction : tap_next

	// ----------------------------------------------------------------
	// Pin synchroniser; the scan clock is only sampled, never used as a clock
	// ----------------------------------------------------------------
	assign pins_raw = '{tck: tck, tms: tms, tdi: tdi, trst_n: trst_n};

	scan_pin_sync u_pin_sync (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.pins      (pins_raw),
		.pins_sync (pins),
		.tck_rise  (tck_rise),
		.tck_fall  (tck_fall)
	);

	// ----------------------------------------------------------------
	// Packet image as seen on capture
	// ----------------------------------------------------------------
	// Status bytes are rebuilt from live inputs at capture time, so status is never stale
	always_comb begin
		logic [1:0] mode_in;
		logic [1:0] mode_hi;
		logic [1:0] mode_lo;
		mode_in = state.ctrl[jtag_packet_pkg::CTRL_INPUT_LSB +: 2];
		mode_hi = state.ctrl[jtag_packet_pkg::CTRL_HIGH_LSB +: 2];
		mode_lo = state.ctrl[jtag_packet_pkg::CTRL_LOW_LSB +: 2];
		packet_image = '1;                                                            // RULE_03
		// Comparator pairs fill the top bytes, first input at the high bit
		packet_image[jtag_packet_pkg::BYTE_FLAGS_A +: 8] = live.supply_flags[19:12];  // RULE_06
		packet_image[jtag_packet_pkg::BYTE_FLAGS_B +: 8] = live.supply_flags[11:4];   // RULE_06
		packet_image[FLAGS_C_LSB +: 4] = live.supply_flags[3:0];
		// Result runs D0 first from bit 3 of its low byte, whose top four bits read one
		packet_image[jtag_packet_pkg::BYTE_RES_LOW +: 4] = rev4(live.result[3:0]);
		packet_image[jtag_packet_pkg::BYTE_RES_HIGH +: 8] = rev8(live.result[11:4]);  // RULE_12
		packet_image[SELECT_LSB +: 4] = rev4(state.set.select);
		packet_image[ATTEN_BIT] = state.set.atten;
		// Input byte: stored override, live pin levels, or all ones in modes 2 and 3
		if (mode_in == jtag_packet_pkg::MODE_SETTINGS) begin
			packet_image[INPUTS_LSB +: 3] = state.set.override;
		end else if (mode_in == jtag_packet_pkg::MODE_LIVE) begin
			packet_image[INPUTS_LSB +: 3] = live.logic_levels;    // RULE_06
		end
		// High output byte
		if (mode_hi == jtag_packet_pkg::MODE_SETTINGS) begin
			packet_image[jtag_packet_pkg::BYTE_DRIVE_HI +: 8] = state.set.drive_high;
		end else if (mode_hi == jtag_packet_pkg::MODE_LIVE) begin
			packet_image[jtag_packet_pkg::BYTE_DRIVE_HI +: 8] = live.driven_levels[13:6];
		end
		// Low output byte, bits 1 and 0 stay one
		if (mode_lo == jtag_packet_pkg::MODE_SETTINGS) begin
			packet_image[DRIVE_LO_LSB +: 6] = state.set.drive_low; // RULE_01
		end else if (mode_lo == jtag_packet_pkg::MODE_LIVE) begin
			packet_image[DRIVE_LO_LSB +: 6] = live.driven_levels[5:0]; // RULE_02
		end
	end

	// ----------------------------------------------------------------
	// Port sequencing and register updates
	// ----------------------------------------------------------------
	always_comb begin
		logic [71:0] din;
		logic        is_ctrl;
		logic        is_packet;
		din       = state.dr_shift;
		is_ctrl   = (state.ir == jtag_packet_pkg::INSTR_CONTROL);
		is_packet = (state.ir == jtag_packet_pkg::INSTR_PACKET);
		next_state       = state;
		next_state.start = 1'b0;
		// Test reset is level sensitive and overrides any scan clock activity
		if (!pins.trst_n) begin
			next_state.tap    = jtag_packet_pkg::TAP_RESET;
			next_state.ir     = jtag_packet_pkg::INSTR_BYPASS;
			next_state.tdo_oe = 1'b0;
		end else if (tck_rise) begin
			// Capture and shift act in the state held at the rising edge
			case (state.tap)
				jtag_packet_pkg::TAP_CAPTURE_IR: begin
					next_state.ir_shift = jtag_packet_pkg::IR_CAPTURE;
				end
				jtag_packet_pkg::TAP_SHIFT_IR: begin
					next_state.ir_shift = {pins.tdi, state.ir_shift[7:1]};  // RULE_14
				end
				jtag_packet_pkg::TAP_CAPTURE_DR: begin
					if (is_packet) begin
						next_state.dr_shift = packet_image;  // RULE_14
					end else if (is_ctrl) begin
						next_state.dr_shift = {60'h0, state.ctrl};
					end else begin
						next_state.dr_shift = 72'h0;
					end
				end
				jtag_packet_pkg::TAP_SHIFT_DR: begin
					// Serial input enters at the top of the selected length
					if (is_packet) begin
						next_state.dr_shift = {pins.tdi, state.dr_shift[71:1]};  // RULE_14
					end else if (is_ctrl) begin
						next_state.dr_shift = {60'h0, pins.tdi, state.dr_shift[11:1]};
					end else begin
						next_state.dr_shift = {71'h0, pins.tdi};
					end
				end
				default: begin
				end
			endcase
			// Every detected rise walks the port one state
			next_state.tap = tap_next(state.tap, pins.tms);
		end else if (tck_fall) begin
			// Output changes on the falling edge so the host samples it stable
			next_state.tdo    = state.tap == jtag_packet_pkg::TAP_SHIFT_IR ? state.ir_shift[0]
			                                                                : state.dr_shift[0];
			next_state.tdo_oe = (state.tap == jtag_packet_pkg::TAP_SHIFT_IR) ||
			                    (state.tap == jtag_packet_pkg::TAP_SHIFT_DR);
			case (state.tap)
				jtag_packet_pkg::TAP_RESET: begin
					next_state.ir = jtag_packet_pkg::INSTR_BYPASS;
				end
				jtag_packet_pkg::TAP_UPDATE_IR: begin
					// An unknown code falls back to the one-bit bypass path
					next_state.ir = state.ir_shift;
				end
				jtag_packet_pkg::TAP_UPDATE_DR: begin
					// New control applies to the next capture, never to the scan in flight
					if (is_ctrl) begin
						next_state.ctrl = din[11:0];  // RULE_14
					end else if (is_packet) begin
						// Status bytes are never written back
						if (state.ctrl[jtag_packet_pkg::CTRL_SELECT_WR]) begin  // RULE_13
							next_state.set.select = rev4(din[SELECT_LSB +: 4]); // RULE_10
							next_state.set.atten  = din[ATTEN_BIT];  // RULE_10
							next_state.start      = 1'b1;  // RULE_10
						end
						if (state.ctrl[jtag_packet_pkg::CTRL_INPUT_LSB +: 2] ==
						    jtag_packet_pkg::MODE_WRITE) begin
							next_state.set.override = din[INPUTS_LSB +: 3]; // RULE_07
						end
						if (state.ctrl[jtag_packet_pkg::CTRL_HIGH_LSB +: 2] ==
						    jtag_packet_pkg::MODE_WRITE) begin
							next_state.set.drive_high = din[jtag_packet_pkg::BYTE_DRIVE_HI +: 8]; // RULE_07
						end
						if (state.ctrl[jtag_packet_pkg::CTRL_LOW_LSB +: 2] ==
						    jtag_packet_pkg::MODE_WRITE) begin
							next_state.set.drive_low = din[DRIVE_LO_LSB +: 6]; // RULE_07
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Test reset leaves the packet settings alone; only core reset restores them
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state.tap             <= jtag_packet_pkg::TAP_RESET;
			state.ir_shift        <= jtag_packet_pkg::IR_CAPTURE;
			state.ir              <= jtag_packet_pkg::INSTR_BYPASS;
			state.ctrl            <= jtag_packet_pkg::CTRL_RESET;
			state.dr_shift        <= 72'h0000_0000_0000_0000_00;
			state.set.drive_high  <= jtag_packet_pkg::DRIVE_HIGH_RESET;  // RULE_04
			state.set.drive_low   <= jtag_packet_pkg::DRIVE_LOW_RESET;   // RULE_04
			state.set.select      <= jtag_packet_pkg::SELECT_RESET;      // RULE_04
			state.set.atten       <= jtag_packet_pkg::ATTEN_RESET;
			state.set.override    <= jtag_packet_pkg::OVERRIDE_RESET;    // RULE_05
			state.start           <= 1'b0;
			state.tdo             <= 1'b0;
			state.tdo_oe          <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// The serial output only means something while its enable is high
	assign tdo              = state.tdo;
	assign tdo_oe           = state.tdo_oe;
	assign settings         = state.set;
	assign conversion_start = state.start;

endmodule : jtag_status_output_register_packet

// File: tb/jtag_packet_asserts.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Port checks on the register packet
// ------------------------------------------------------------
module jtag_packet_asserts (
	input wire logic                          core_clk,
	input wire logic                          rst_n,
	input wire logic                          tck,
	input wire logic                          tdo,
	input wire logic                          tdo_oe,
	input wire jtag_packet_pkg::settings_type settings,
	input wire logic                          conversion_start
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// Pin synchroniser holds the port quiet, so reset values show at release
	a_reset_drive: assert property ($rose(rst_n) |->
		settings.drive_high == 8'h04 && settings.drive_low == 6'h00)
		else $error("drive settings wrong after reset");
	a_reset_override: assert property ($rose(rst_n) |-> settings.override == 3'h0)
		else $error("override wrong after reset");
	a_reset_select: assert property ($rose(rst_n) |->
		settings.select == 4'h0 && !settings.atten && !conversion_start)
		else $error("selector wrong after reset");
	a_reset_idle: assert property ($rose(rst_n) |-> !tdo_oe && !tdo)
		else $error("serial output active after reset");
	a_start_pulse: assert property (conversion_start |=> !conversion_start [*8])
		else $error("conversion start not a single pulse");
	// Updates land on the detected fall, well inside the low half of tck
	a_settings_tck: assert property ($past(rst_n) && $changed(settings) |-> !tck)
		else $error("settings changed outside an update");
	a_tdo_tck: assert property ($past(rst_n) && $changed(tdo) |-> !tck)
		else $error("serial output changed while tck high");
	a_oe_tck: assert property ($past(rst_n) && $changed(tdo_oe) |-> !tck)
		else $error("output enable changed while tck high");

	cover property (conversion_start);
	cover property ($rose(tdo_oe));
	cover property ($changed(settings.drive_high));
endmodule : jtag_packet_asserts

bind jtag_status_output_register_packet jtag_packet_asserts i_chk (
	.core_clk, .rst_n, .tck, .tdo, .tdo_oe, .settings, .conversion_start);

// File: tb/jtag_host_model.sv
`timescale 1ns/1ps

// Scan host: tck stands low between frames, pins change with tck low
module jtag_host_model (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	output logic      trst_n,
	input  wire logic tdo,
	input  wire logic tdo_oe
);
	initial begin
		tck = 1'b0;
		tms = 1'b0;
		tdi = 1'b0;
		trst_n = 1'b0;
	end

	// One scan clock; an undriven output never matches an expectation
	task automatic tick(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#80 tck = 1'b1;
		o = tdo_oe ? tdo : 1'bx;
		#80 tck = 1'b0;
	endtask : tick

	task automatic run(input int n);
		logic o;
		repeat (n) tick(1'b0, 1'b0, o);
	endtask : run

	task automatic port_reset();
		trst_n = 1'b0;
		#400 trst_n = 1'b1;
		#400 run(1);
	endtask : port_reset

	// Idle to shift, n bits LSB first, update, back to idle
	task automatic scan(input bit ir, input int n, input logic [71:0] d, output logic [71:0] q);
		logic o;
		q = '1;
		tick(1'b1, 1'b0, o);
		if (ir)
			tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
		tick(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, d[i], o);
			q[i] = o;
		end
		tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
	endtask : scan
endmodule : jtag_host_model

// File: tb/jtag_status_output_register_packet_tb.sv
`timescale 1ns/1ps

module jtag_status_output_register_packet_tb;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic tck, tms, tdi, trst_n, tdo, tdo_oe, conversion_start;
	jtag_packet_pkg::live_status_type live = '0;
	jtag_packet_pkg::settings_type    settings;
	jtag_packet_pkg::settings_type    ws = '{8'h04, 6'h00, 3'h0, 4'h0, 1'b0};
	logic [71:0] exp_q[$];
	logic [71:0] got;
	logic [7:0]  starts = '0;
	logic [7:0]  ns = '0;
	logic [31:0] seed = 32'h08c4;
	logic [11:0] rc[3] = '{12'h000, 12'h015, 12'h03F};
	int bad_count = 0;
	int check_count = 0;
	int cycles = 0;
	event got_ev;

	jtag_status_output_register_packet i_dut (.core_clk, .rst_n, .tck, .tms, .tdi, .trst_n,
		.tdo, .tdo_oe, .live, .settings, .conversion_start);
	jtag_host_model i_host (.tck, .tms, .tdi, .trst_n, .tdo, .tdo_oe);

	always #2.5 core_clk = ~core_clk;

	// Timeout well above the expected run of some 56000 cycles
	always @(posedge core_clk) begin
		cycles++;
		starts <= starts + 8'(conversion_start === 1'b1);
		if (cycles == 80000) begin
			bad_count++;
			summarize();
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function automatic logic [7:0] pick(input logic [1:0] m, input logic [7:0] k, input logic [7:0] s);
		return m == 2'h0 ? k : (m == 2'h1 ? s : 8'hFF);
	endfunction : pick

	// Expected packet image; unused positions stay one
	function automatic logic [71:0] image(input logic [11:0] c);
		logic [71:0] p;
		p = '1;
		p[71:52] = live.supply_flags;
		for (int i = 0; i < 12; i++) p[43 - i] = live.result[i];
		for (int i = 0; i < 4; i++) p[31 - i] = ws.select[i];
		p[27] = ws.atten;
		p[23:16] = pick(c[5:4], {1'b1, ws.override, 4'hF}, {1'b1, live.logic_levels, 4'hF});
		p[15:8] = pick(c[3:2], ws.drive_high, live.driven_levels[13:6]);
		p[7:0] = pick(c[1:0], {ws.drive_low, 2'b11}, {live.driven_levels[5:0], 2'b11});
		return p;
	endfunction : image

	task automatic check(input logic [71:0] seen, input logic [71:0] want);
		check_count++;
		if (seen !== want) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : check

	// Watcher: each reported result is compared with the oldest note
	always @(got_ev) check(got, exp_q.pop_front());

	task automatic set_ctrl(input logic [11:0] c);
		logic [71:0] o;
		i_host.scan(1'b1, 8, 72'h1A, o);
		i_host.scan(1'b0, 12, {60'h0, c}, o);
		i_host.scan(1'b1, 8, 72'h19, o);
	endtask : set_ctrl

	task automatic write_pkt(input logic [11:0] c, input logic [71:0] d);
		logic [71:0] o;
		set_ctrl(c);
		if (c[5:4] == 2'h2) ws.override = d[22:20];
		if (c[3:2] == 2'h2) ws.drive_high = d[15:8];
		if (c[1:0] == 2'h2) ws.drive_low = d[7:2];
		if (c[6]) begin
			for (int i = 0; i < 4; i++) ws.select[i] = d[31 - i];
			ws.atten = d[27];
			ns++;
		end
		exp_q.push_back({42'h0, ws, ns});
		i_host.scan(1'b0, 72, d, o);
		got = {42'h0, settings, starts};
		->got_ev;
	endtask : write_pkt

	task automatic read_pkt(input logic [11:0] c);
		logic [71:0] o;
		set_ctrl(c);
		@(posedge core_clk);
		live <= 49'({rnd(), rnd()});
		@(posedge core_clk);
		exp_q.push_back(image(c));
		#1;
		i_host.scan(1'b0, 72, '1, o);
		got = o;
		->got_ev;
	endtask : read_pkt

	task automatic summarize();
		if (bad_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize

	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		exp_q.push_back({42'h0, ws, ns});
		got = {42'h0, settings, starts};
		->got_ev;
		#1; // Keeps scan pin edges off the core clock edges
		i_host.port_reset();
		write_pkt(12'h040, 72'h00_0000_0000_2800_0000);
		i_host.run(1000);
		write_pkt(12'h02A, {rnd(), rnd(), 8'h00});
		write_pkt(12'h06A, {rnd(), rnd(), 8'h00});
		foreach (rc[k]) read_pkt(rc[k]);
		@(posedge core_clk); // Lets the watcher take the last note first
		summarize();
	end
endmodule : jtag_status_output_register_packet_tb
